// ==== logic/bcirq_consts.svh ====
`ifndef BCIRQ_CONSTS_SVH
`define BCIRQ_CONSTS_SVH

//------------------------------------------------------------
// Register offsets
//------------------------------------------------------------
`define BCIRQ_OFS_PENDING    8'h07
`define BCIRQ_OFS_ENABLE     8'h10
`define BCIRQ_OFS_OUTEN      8'h14
`define BCIRQ_OFS_SYS_STATUS 8'h20
`define BCIRQ_OFS_SYS_MASK   8'h21

//------------------------------------------------------------
// Field positions and reset values
//------------------------------------------------------------
`define BCIRQ_BIT_FRAME_TMR  15
`define BCIRQ_BIT_SEL_MSG    14
`define BCIRQ_BIT_GPQ_WRAP   13
`define BCIRQ_SYS_LOG_WRAP   0
`define BCIRQ_SYS_LOG_DROP   1
`define BCIRQ_SYS_W          2
`define BCIRQ_RST_REG        16'h0000
`define BCIRQ_RST_SYS        2'h0

//------------------------------------------------------------
// Interrupt log ring
//------------------------------------------------------------
`define BCIRQ_LOG_BASE       16'h0180
`define BCIRQ_LOG_WORDS      64

`endif

// ==== logic/bcirq_pkg.sv ====
package bcirq_pkg;
    // Log writer: idle, or second word of an entry still to write
    typedef enum logic {
        BCIRQ_LOG_IDLE   = 1'b0,
        BCIRQ_LOG_SECOND = 1'b1
    } bcirq_log_state_t;
endpackage

// ==== logic/bcirq_log_writer.sv ====
`timescale 1ns/1ps
`include "bcirq_consts.svh"

module bcirq_log_writer
    import bcirq_pkg::*;
#(
    parameter int LOG_WORDS = `BCIRQ_LOG_WORDS
) (
    // Clock and control
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        ce,
    // Entry request
    input  wire logic        start,
    input  wire logic [15:0] iiw,
    input  wire logic [15:0] iaw,
    output logic             busy,
    // RAM write port
    output logic             wr_en,
    output logic [15:0]      wr_addr,
    output logic [15:0]      wr_data,
    // Ring wrapped back to base
    output logic             wrapped
);
    localparam int PW = $clog2(LOG_WORDS);

    bcirq_log_state_t  state_ff;
    logic [PW-1:0]     ptr_ff;
    logic [15:0]       iaw_hold_ff;
    logic              wr_en_ff;
    logic [15:0]       wr_addr_ff;
    logic [15:0]       wr_data_ff;
    logic              wrapped_ff;
    logic              do_write;

    assign busy     = (state_ff == BCIRQ_LOG_SECOND);
    assign do_write = (state_ff == BCIRQ_LOG_IDLE) ? start : 1'b1;
    assign wr_en    = wr_en_ff;
    assign wr_addr  = wr_addr_ff;
    assign wr_data  = wr_data_ff;
    assign wrapped  = wrapped_ff;

    //------------------------------------------------------------
    // Entry sequencing: identification word, then address word
    //------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            state_ff    <= BCIRQ_LOG_IDLE;
            iaw_hold_ff <= 16'h0000;
        end else if (ce) begin
            unique case (state_ff)
                BCIRQ_LOG_IDLE: begin
                    if (start) begin
                        state_ff    <= BCIRQ_LOG_SECOND;
                        iaw_hold_ff <= iaw;
                    end
                end
                BCIRQ_LOG_SECOND: begin
                    state_ff <= BCIRQ_LOG_IDLE;
                end
            endcase
        end
    end

    // Ring pointer and write port; pointer rolls over after the last word
    always_ff @(posedge clock) begin
        if (rst) begin
            ptr_ff     <= '0;
            wr_en_ff   <= 1'b0;
            wr_addr_ff <= 16'h0000;
            wr_data_ff <= 16'h0000;
            wrapped_ff <= 1'b0;
        end else if (ce) begin
            wr_en_ff   <= do_write;
            wrapped_ff <= busy && (ptr_ff == PW'(LOG_WORDS - 1));
            if (do_write) begin
                wr_addr_ff <= `BCIRQ_LOG_BASE + 16'(ptr_ff);
                wr_data_ff <= busy ? iaw_hold_ff : iiw;
                ptr_ff     <= ptr_ff + 1'b1;
            end
        end
    end

    //------------------------------------------------------------
    // Checks
    //------------------------------------------------------------
    log_pair_a: assert property (
        @(posedge clock) disable iff (rst)
        ce && start && !busy ##1 ce |=> wr_en && wr_data == $past(iaw, 2)
    ) else $error("address word did not follow identification word");

    log_range_a: assert property (
        @(posedge clock) disable iff (rst)
        wr_en |-> wr_addr >= `BCIRQ_LOG_BASE &&
                  wr_addr < `BCIRQ_LOG_BASE + 16'(LOG_WORDS)
    ) else $error("log write outside its ring");
endmodule

// ==== logic/bcirq_regs.sv ====
`timescale 1ns/1ps
`include "bcirq_consts.svh"

module bcirq_regs
    import bcirq_pkg::*;
#(
    parameter int LOG_WORDS = `BCIRQ_LOG_WORDS
) (
    // Clock, reset and clock enable
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        ce,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [15:0]      reg_rdata,
    // Controller events, one-cycle pulses
    input  wire logic        frame_timer_expired_evt,
    input  wire logic        selected_message_done_evt,
    input  wire logic        gp_queue_wrap_evt,
    input  wire logic [12:3] other_evt,
    // Message completion and its control/status block address
    input  wire logic        msg_done,
    input  wire logic [15:0] msg_block_addr,
    // Host interrupt and hardware pending summary
    output logic             host_irq_n,
    output logic             controller_summary_flag,
    // Interrupt log RAM write port
    output logic             log_wr_en,
    output logic [15:0]      log_wr_addr,
    output logic [15:0]      log_wr_data,
    // Block status interrupt
    output logic             sys_irq
);
    //------------------------------------------------------------
    // State
    //------------------------------------------------------------
    logic [15:0]            enable_ff;
    logic [15:0]            outen_ff;
    logic [15:0]            pending_ff;
    logic [15:0]            msg_acc_ff;
    logic                   irq_n_ff;
    logic                   summary_ff;
    logic [15:0]            rdata_ff;
    logic [`BCIRQ_SYS_W-1:0] sys_status_ff;
    logic [`BCIRQ_SYS_W-1:0] sys_mask_ff;

    logic [15:0]            evt_raw;
    logic [15:0]            evt_en;
    logic [15:0]            nxt_pending;
    logic [15:0]            nxt_outen;
    logic [15:0]            nxt_msg_acc;
    logic [15:0]            msg_iiw;
    logic                   nxt_irq_active;
    logic                   rd_pending;
    logic                   log_start;
    logic                   log_busy;
    logic                   log_wrapped;
    logic [`BCIRQ_SYS_W-1:0] sys_set;

    // Address match shared by the register writes and the pending read-clear
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction

    //------------------------------------------------------------
    // Event gating
    //------------------------------------------------------------
    // Bits 2-0 carry no shared event here, so they never set
    always_comb begin
        evt_raw = 16'h0000;
        evt_raw[`BCIRQ_BIT_FRAME_TMR] = frame_timer_expired_evt;
        evt_raw[`BCIRQ_BIT_SEL_MSG]   = selected_message_done_evt;
        evt_raw[`BCIRQ_BIT_GPQ_WRAP]  = gp_queue_wrap_evt;
        evt_raw[12:3]                 = other_evt;
    end

    // Only the mask at the moment of the event counts; disabled events
    // leave no trace, so a later enable cannot resurrect them
    assign evt_en = evt_raw & enable_ff;

    //------------------------------------------------------------
    // Next values
    //------------------------------------------------------------
    assign rd_pending = reg_rd && hit(reg_addr, `BCIRQ_OFS_PENDING);

    // Read clears, but an event in the same cycle survives the clear
    assign nxt_pending = (rd_pending ? `BCIRQ_RST_REG : pending_ff)
                       | evt_en;

    assign nxt_outen = (reg_wr && hit(reg_addr, `BCIRQ_OFS_OUTEN))
                     ? reg_wdata : outen_ff;

    // Events gathered through one message, including its last cycle
    assign msg_iiw     = msg_acc_ff | evt_en;
    assign nxt_msg_acc = msg_done ? `BCIRQ_RST_REG : msg_iiw;

    // Line goes low only at message completion, then holds while any
    // output-enabled pending bit is still uncleared
    assign nxt_irq_active = (msg_done || !irq_n_ff)
                          && |(nxt_pending & nxt_outen);

    assign log_start = ce && msg_done && |msg_iiw;

    //------------------------------------------------------------
    // Software registers and per-message accumulator
    //------------------------------------------------------------
    // Enable mask
    always_ff @(posedge clock) begin
        if (rst) begin
            enable_ff <= `BCIRQ_RST_REG;
        end else if (ce && reg_wr && hit(reg_addr, `BCIRQ_OFS_ENABLE)) begin
            enable_ff <= reg_wdata;
        end
    end

    // Output enable mask
    always_ff @(posedge clock) begin
        if (rst) begin
            outen_ff <= `BCIRQ_RST_REG;
        end else if (ce) begin
            outen_ff <= nxt_outen;
        end
    end

    // Pending register, read-to-clear; writes have no effect
    always_ff @(posedge clock) begin
        if (rst) begin
            pending_ff <= `BCIRQ_RST_REG;
        end else if (ce) begin
            pending_ff <= nxt_pending;
        end
    end

    // Per-message accumulator
    always_ff @(posedge clock) begin
        if (rst) begin
            msg_acc_ff <= `BCIRQ_RST_REG;
        end else if (ce) begin
            msg_acc_ff <= nxt_msg_acc;
        end
    end

    //------------------------------------------------------------
    // Host interrupt and summary flag
    //------------------------------------------------------------
    // One shared line for all output-enabled events
    always_ff @(posedge clock) begin
        if (rst) begin
            irq_n_ff <= 1'b1;
        end else if (ce) begin
            irq_n_ff <= !nxt_irq_active;
        end
    end

    // Summary follows zero/non-zero state of the pending register
    always_ff @(posedge clock) begin
        if (rst) begin
            summary_ff <= 1'b0;
        end else if (ce) begin
            summary_ff <= |nxt_pending;
        end
    end

    assign host_irq_n              = irq_n_ff;
    assign controller_summary_flag = summary_ff;

    //------------------------------------------------------------
    // Block status: log wrap and dropped entries
    //------------------------------------------------------------
    // A message ending while the writer is still busy loses its entry;
    // messages are far longer than two cycles, so this flags a fault
    assign sys_set[`BCIRQ_SYS_LOG_WRAP] = log_wrapped;
    assign sys_set[`BCIRQ_SYS_LOG_DROP] = log_start && log_busy;

    // Write one to clear; a set in the same cycle wins
    always_ff @(posedge clock) begin
        if (rst) begin
            sys_status_ff <= `BCIRQ_RST_SYS;
        end else if (ce) begin
            if (reg_wr && hit(reg_addr, `BCIRQ_OFS_SYS_STATUS)) begin
                sys_status_ff <= (sys_status_ff
                               & ~reg_wdata[`BCIRQ_SYS_W-1:0]) | sys_set;
            end else begin
                sys_status_ff <= sys_status_ff | sys_set;
            end
        end
    end

    // Status mask
    always_ff @(posedge clock) begin
        if (rst) begin
            sys_mask_ff <= `BCIRQ_RST_SYS;
        end else if (ce && reg_wr && hit(reg_addr, `BCIRQ_OFS_SYS_MASK)) begin
            sys_mask_ff <= reg_wdata[`BCIRQ_SYS_W-1:0];
        end
    end

    assign sys_irq = |(sys_status_ff & sys_mask_ff);

    //------------------------------------------------------------
    // Read data, valid the cycle after the strobe only
    //------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            rdata_ff <= 16'h0000;
        end else if (ce) begin
            rdata_ff <= 16'h0000;
            if (reg_rd) begin
                unique case (reg_addr)
                    `BCIRQ_OFS_PENDING:    rdata_ff <= pending_ff;
                    `BCIRQ_OFS_ENABLE:     rdata_ff <= enable_ff;
                    `BCIRQ_OFS_OUTEN:      rdata_ff <= outen_ff;
                    `BCIRQ_OFS_SYS_STATUS: rdata_ff <= 16'(sys_status_ff);
                    `BCIRQ_OFS_SYS_MASK:   rdata_ff <= 16'(sys_mask_ff);
                    default:               rdata_ff <= 16'h0000;
                endcase
            end
        end
    end

    assign reg_rdata = rdata_ff;

    //------------------------------------------------------------
    // Interrupt log writer
    //------------------------------------------------------------
    // Entry: identification word (events), then the message block address
    bcirq_log_writer #(
        .LOG_WORDS (LOG_WORDS)
    ) u_log (
        .clock   (clock),
        .rst     (rst),
        .ce      (ce),
        .start   (log_start && !log_busy),
        .iiw     (msg_iiw),
        .iaw     (msg_block_addr),
        .busy    (log_busy),
        .wr_en   (log_wr_en),
        .wr_addr (log_wr_addr),
        .wr_data (log_wr_data),
        .wrapped (log_wrapped)
    );

    //------------------------------------------------------------
    // Checks
    //------------------------------------------------------------
    mask_gate_a: assert property (
        @(posedge clock) disable iff (rst)
        ce && !enable_ff[`BCIRQ_BIT_FRAME_TMR]
           && !pending_ff[`BCIRQ_BIT_FRAME_TMR]
        |=> !pending_ff[`BCIRQ_BIT_FRAME_TMR]
    ) else $error("disabled frame timer event was recorded");

    pend_set_a: assert property (
        @(posedge clock) disable iff (rst)
        ce && |evt_en |=> (pending_ff & $past(evt_en)) == $past(evt_en)
    ) else $error("enabled event did not set its pending bit");

    rd_clear_a: assert property (
        @(posedge clock) disable iff (rst)
        ce && rd_pending && evt_en == 16'h0000
        |=> pending_ff == 16'h0000 && reg_rdata == $past(pending_ff)
    ) else $error("pending read did not return and clear");

    summary_flag_a: assert property (
        @(posedge clock) disable iff (rst)
        ce && |evt_en |=> controller_summary_flag
    ) else $error("summary flag missing after pending set");

    irq_at_done_a: assert property (
        @(posedge clock) disable iff (rst)
        ce && msg_done && |(nxt_pending & nxt_outen) |=> !host_irq_n
    ) else $error("interrupt not raised at message completion");

    irq_early_a: assert property (
        @(posedge clock) disable iff (rst)
        ce && host_irq_n && !msg_done |=> host_irq_n
    ) else $error("interrupt raised before message completion");

    irq_cause_a: assert property (
        @(posedge clock) disable iff (rst)
        !host_irq_n |-> |(pending_ff & outen_ff)
    ) else $error("interrupt low without an output-enabled pending bit");

    irq_release_a: assert property (
        @(posedge clock) disable iff (rst)
        ce && rd_pending && evt_en == 16'h0000 |=> host_irq_n
    ) else $error("interrupt held after pending register was read");

    log_entry_a: assert property (
        @(posedge clock) disable iff (rst)
        log_start && !log_busy
        |=> log_wr_en && log_wr_data == $past(msg_iiw)
    ) else $error("log entry missing at message completion");

    // Events of the completing cycle belong to the ending message, so
    // the accumulator starts the next message empty
    acc_report_a: assert property (
        @(posedge clock) disable iff (rst)
        ce && msg_done |=> msg_acc_ff == 16'h0000
    ) else $error("message accumulator not restarted");

    sys_irq_a: assert property (
        @(posedge clock) disable iff (rst)
        ce && log_wrapped && sys_mask_ff[`BCIRQ_SYS_LOG_WRAP] && !reg_wr
        |=> sys_irq
    ) else $error("log wrap did not raise block interrupt");
endmodule

// ==== testbench/bcirq_log_ram_model.sv ====
`timescale 1ns/1ps

module bcirq_log_ram_model (
    // Clock
    input  wire logic        clock,
    // RAM write port from the log writer
    input  wire logic        wr_en,
    input  wire logic [15:0] wr_addr,
    input  wire logic [15:0] wr_data,
    // Write outside the ring seen
    output logic             stray,
    // Words written so far
    output logic [15:0]      wcount
);
    //--------------------------------------------------------
    // Ring storage
    //--------------------------------------------------------
    logic [15:0] mem [0:63];

    // Zero start so that a missing write never matches by luck
    initial begin
        for (int i = 0; i < 64; i++) begin
            mem[i] = 16'h0000;
        end
        stray  = 1'b0;
        wcount = 16'h0000;
    end

    // Accept only the fixed log range, flag anything else
    always @(posedge clock) begin
        if (wr_en === 1'b1) begin
            wcount <= wcount + 16'h0001;
            if (wr_addr >= 16'h0180 && wr_addr <= 16'h01bf) begin
                mem[wr_addr - 16'h0180] <= wr_data;
            end else begin
                stray <= 1'b1;
            end
        end
    end
endmodule

// ==== testbench/bus_controller_irq_regs_tb.sv ====
`timescale 1ns/1ps
`include "bcirq_consts.svh"

module bus_controller_irq_regs_tb;
    //--------------------------------------------------------
    // Signals
    //--------------------------------------------------------
    localparam int LOGW = 8;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic        fte = 1'b0;
    logic        sme = 1'b0;
    logic        gqe = 1'b0;
    logic [12:3] other_evt = 10'h000;
    logic        msg_done = 1'b0;
    logic [15:0] msg_block_addr = 16'h0000;
    logic        host_irq_n, summary, log_wr_en, sys_irq, stray;
    logic [15:0] log_wr_addr, log_wr_data, wcount, rv;
    logic [15:0] nlog = 16'h0000;
    int          mismatches = 0;
    int          tests_run = 0;
    int          cycles = 0;

    bcirq_regs #(.LOG_WORDS(LOGW)) uut (
        .clock(clock), .rst(rst), .ce(ce),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .frame_timer_expired_evt(fte), .selected_message_done_evt(sme),
        .gp_queue_wrap_evt(gqe), .other_evt(other_evt),
        .msg_done(msg_done), .msg_block_addr(msg_block_addr),
        .host_irq_n(host_irq_n), .controller_summary_flag(summary),
        .log_wr_en(log_wr_en), .log_wr_addr(log_wr_addr),
        .log_wr_data(log_wr_data), .sys_irq(sys_irq)
    );

    bcirq_log_ram_model m (
        .clock(clock), .wr_en(log_wr_en), .wr_addr(log_wr_addr),
        .wr_data(log_wr_data), .stray(stray), .wcount(wcount)
    );

    //--------------------------------------------------------
    // Clock and hang guard
    //--------------------------------------------------------
    always #5 clock = ~clock;

    // The whole sequence needs about a hundred cycles
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches = mismatches + 1;
            test_done();
        end
    end

    //--------------------------------------------------------
    // Tasks
    //--------------------------------------------------------
    task automatic test_done();
        if (mismatches == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr    <= 1'b0;
        #1;
    endtask

    // Read data stands only in the cycle after the strobe edge
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd   <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask

    // One cycle of event pulses, optionally with message completion
    task automatic ev(input logic [15:0] e, input logic done);
        @(posedge clock);
        fte            <= e[15];
        sme            <= e[14];
        gqe            <= e[13];
        other_evt      <= e[12:3];
        msg_done       <= done;
        msg_block_addr <= 16'h0c00 + nlog;
        @(posedge clock);
        {fte, sme, gqe, other_evt, msg_done} <= 14'h0000;
        #1;
    endtask

    // Both words of the newest entry land at the ring pointer
    task automatic entry(input logic [15:0] w);
        int idx;
        idx = (2 * nlog) % LOGW;
        repeat (2) @(posedge clock);
        #1;
        chk(m.mem[idx], w);
        chk(m.mem[idx + 1], 16'h0c00 + nlog);
        nlog = nlog + 16'h0001;
    endtask

    //--------------------------------------------------------
    // Main sequence
    //--------------------------------------------------------
    initial begin
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        // Reset state and unmapped or read-only places
        rd(`BCIRQ_OFS_ENABLE, 16'h0000);
        rd(`BCIRQ_OFS_OUTEN, 16'h0000);
        rd(`BCIRQ_OFS_SYS_STATUS, 16'h0000);
        chk({15'h0, host_irq_n}, 16'h0001);
        rd(8'h3f, 16'h0000);
        wr(`BCIRQ_OFS_PENDING, 16'hffff);
        rd(`BCIRQ_OFS_PENDING, 16'h0000);
        // Disabled events leave no trace, even once enabled later
        ev(16'he000, 1'b1);
        chk({15'h0, summary}, 16'h0000);
        chk({15'h0, host_irq_n}, 16'h0001);
        wr(`BCIRQ_OFS_ENABLE, 16'he000);
        rd(`BCIRQ_OFS_PENDING, 16'h0000);
        chk(wcount, 16'h0000);
        // Low priority: recorded and logged, no interrupt
        ev(16'he000, 1'b1);
        chk({15'h0, summary}, 16'h0001);
        chk({15'h0, host_irq_n}, 16'h0001);
        entry(16'he000);
        rd(`BCIRQ_OFS_PENDING, 16'he000);
        chk({15'h0, summary}, 16'h0000);
        rd(`BCIRQ_OFS_PENDING, 16'h0000);
        // Events accumulate, interrupt waits for completion
        wr(`BCIRQ_OFS_OUTEN, 16'h4000);
        ev(16'h8000, 1'b0);
        ev(16'h2000, 1'b0);
        chk({15'h0, host_irq_n}, 16'h0001);
        ev(16'h4000, 1'b1);
        chk({15'h0, host_irq_n}, 16'h0000);
        entry(16'he000);
        chk({15'h0, host_irq_n}, 16'h0000);
        rd(`BCIRQ_OFS_PENDING, 16'he000);
        chk({15'h0, host_irq_n}, 16'h0001);
        // Shared bits 12..3 map straight through
        wr(`BCIRQ_OFS_ENABLE, 16'hffff);
        wr(`BCIRQ_OFS_OUTEN, 16'hffff);
        rd(`BCIRQ_OFS_ENABLE, 16'hffff);
        rd(`BCIRQ_OFS_OUTEN, 16'hffff);
        ev(16'h1ff8, 1'b1);
        chk({15'h0, host_irq_n}, 16'h0000);
        entry(16'h1ff8);
        rd(`BCIRQ_OFS_PENDING, 16'h1ff8);
        // Fourth entry fills the shortened ring and wraps it
        ev(16'h8000, 1'b1);
        entry(16'h8000);
        rd(`BCIRQ_OFS_PENDING, 16'h8000);
        rd(`BCIRQ_OFS_SYS_STATUS, 16'h0001);
        chk({15'h0, sys_irq}, 16'h0000);
        wr(`BCIRQ_OFS_SYS_MASK, 16'h0001);
        chk({15'h0, sys_irq}, 16'h0001);
        wr(`BCIRQ_OFS_SYS_STATUS, 16'h0001);
        chk({15'h0, sys_irq}, 16'h0000);
        // Back-to-back completions: second entry dropped
        // Event held over both completions, so the second has content
        @(posedge clock);
        fte            <= 1'b1;
        msg_done       <= 1'b1;
        msg_block_addr <= 16'h0c00 + nlog;
        repeat (2) @(posedge clock);
        {fte, msg_done} <= 2'b00;
        entry(16'h8000);
        // Clock enable low: a whole completion is ignored
        @(posedge clock);
        ce <= 1'b0;
        ev(16'h2000, 1'b1);
        @(posedge clock);
        ce <= 1'b1;
        rd(`BCIRQ_OFS_SYS_STATUS, 16'h0002);
        chk(wcount, 16'h000a);
        chk({15'h0, stray}, 16'h0000);
        rd(`BCIRQ_OFS_PENDING, 16'h8000);
        test_done();
    end
endmodule
